//--- design/adc_out_pkg.sv
// Shared constants for the converter sample output and configuration block
package adc_out_pkg;
   localparam int WORD_W = 12;
   localparam int MV_W = 16;
   localparam logic [11:0] CODE_MAX = 12'hFFF;
   localparam logic [11:0] CODE_MID = 12'h800;
   localparam logic [11:0] CODE_MIN = 12'h000;
   localparam logic [15:0] SPAN_SMALL_MV = 16'h07D0;
   localparam logic [15:0] SPAN_LARGE_MV = 16'h0BB8;
   localparam logic [15:0] SPAN_FLOOR_MV = 16'h0001;
   localparam logic RANGE_PULL = 1'b0;
   localparam logic REFSRC_PULL = 1'b1;
   localparam int SYNC_STAGES = 2;
   localparam int REF_LAT_CYCLES = 9;
   localparam int REF_DLY_STAGES = REF_LAT_CYCLES - SYNC_STAGES;
   localparam int PIPE_DEPTH = 6;
   localparam int CLK_PERIOD_NS = 20;
   localparam int FIFO_W = WORD_W + 1;
endpackage

//--- design/adc_sample_output.sv
// Digital side of the 12-bit converter: sampling, coding, over-range and configuration
//
// Summary of operation
// - Each sample is taken on the rising edge of the sample clock.
// - Over-range flag travels with its own sample word through the pipeline.
// - Flag is low when the sample lies inside the selected range.
// - Flag is high when the sample exceeds the selected range.
// - Words are straight offset binary: all ones, midpoint 800, all zeros.
// - Internal reference: range pin low gives small span, high gives large.
// - Range pin is pulled down, so open pin gives the small span.
// - In external reference mode the range pin has no effect.
// - Reference select high means external reference, low means internal.
// - Reference select is pulled up, so open pin means external reference.
// - External reference changes show in results after nine sample clocks.
`timescale 1ns/10ps
module adc_sample_output
   import adc_out_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clkEn,
   // Analog proxies in millivolts
   input wire logic signed [MV_W-1:0] diffInMv,
   input wire logic [MV_W-1:0] refTopMv,
   input wire logic [MV_W-1:0] refBotMv,
   // Configuration pins, each with a driven indication
   input wire logic rangeSelectPin,
   input wire logic rangeSelectPinDriven,
   input wire logic referenceSourceSelect,
   input wire logic referenceSourceSelectDriven,
   // Sample output
   output logic [WORD_W-1:0] sampleWord,
   output logic overrangeFlag,
   output logic sampleValid,
   input wire logic sampleReady
);
   // Pin levels after the pull networks
   wire logic rangeLevel = rangeSelectPinDriven ? rangeSelectPin : RANGE_PULL;
   wire logic refLevel = referenceSourceSelectDriven ? referenceSourceSelect : REFSRC_PULL;

   logic [SYNC_STAGES-1:0] rangeSync_r;
   logic [SYNC_STAGES-1:0] refSync_r;
   logic signed [MV_W-1:0] diffMeta_r;
   logic signed [MV_W-1:0] heldSample_r;
   logic [MV_W-1:0] topMeta_r;
   logic [MV_W-1:0] topSync_r;
   logic [MV_W-1:0] botMeta_r;
   logic [MV_W-1:0] botSync_r;
   logic [MV_W-1:0] extDly_r [REF_DLY_STAGES];
   logic [WORD_W:0] pipe_r [PIPE_DEPTH];
   logic [PIPE_DEPTH-1:0] pipeValid_r;
   logic [3:0] enRun_r;
   logic fifoInReady;

   // The second stage of the sample path is the track-and-hold capture
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rangeSync_r <= '0;
         refSync_r <= '0;
         diffMeta_r <= '0;
         heldSample_r <= '0;
         topMeta_r <= '0;
         topSync_r <= '0;
         botMeta_r <= '0;
         botSync_r <= '0;
      end else if (clkEn) begin
         rangeSync_r <= {rangeSync_r[0], rangeLevel};
         refSync_r <= {refSync_r[0], refLevel};
         diffMeta_r <= diffInMv;
         heldSample_r <= diffMeta_r;
         topMeta_r <= refTopMv;
         topSync_r <= topMeta_r;
         botMeta_r <= refBotMv;
         botSync_r <= botMeta_r;
      end
   end

   wire logic rangeLarge = rangeSync_r[SYNC_STAGES-1];
   wire logic refExternal = refSync_r[SYNC_STAGES-1];

   // External span, with a floor so a crossed pair never divides by zero
   wire logic signed [MV_W:0] extDiff = $signed({1'b0, topSync_r}) - $signed({1'b0, botSync_r});
   wire logic [MV_W-1:0] extSpanRaw = (extDiff > 0) ? extDiff[MV_W-1:0] : SPAN_FLOOR_MV;

   // Reference delay line; it keeps running during output stalls
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         for (int i = 0; i < REF_DLY_STAGES; i++) begin
            extDly_r[i] <= SPAN_SMALL_MV;
         end
      end else if (clkEn) begin
         extDly_r[0] <= extSpanRaw;
         for (int i = 1; i < REF_DLY_STAGES; i++) begin
            extDly_r[i] <= extDly_r[i-1];
         end
      end
   end

   wire logic [MV_W-1:0] extSpan = extDly_r[REF_DLY_STAGES-1];
   wire logic [MV_W-1:0] intSpan = rangeLarge ? SPAN_LARGE_MV : SPAN_SMALL_MV;
   wire logic [MV_W-1:0] activeSpan = refExternal ? extSpan : intSpan;

   // Offset binary conversion on doubled values, so an odd span keeps an exact midpoint
   wire logic signed [MV_W+1:0] offs = $signed({heldSample_r[MV_W-1], heldSample_r, 1'b0})
      + $signed({2'b00, activeSpan});
   wire logic below = offs < 0;
   wire logic above = offs >= $signed({1'b0, activeSpan, 1'b0});
   wire logic [MV_W+WORD_W:0] scaled = {offs[MV_W:0], CODE_MIN};
   wire logic [MV_W+WORD_W:0] quot = scaled / {{WORD_W{1'b0}}, activeSpan, 1'b0};
   wire logic convOvr = below || above;
   wire logic [WORD_W-1:0] convCode = below ? CODE_MIN :
      (above ? CODE_MAX : quot[WORD_W-1:0]);

   // Pipeline advances only on enabled cycles when the buffer can accept, so no word is dropped
   wire logic advance = clkEn && fifoInReady;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pipeValid_r <= '0;
         for (int i = 0; i < PIPE_DEPTH; i++) begin
            pipe_r[i] <= '0;
         end
      end else if (advance) begin
         pipe_r[0] <= {convOvr, convCode};
         pipeValid_r <= {pipeValid_r[PIPE_DEPTH-2:0], 1'b1};
         for (int i = 1; i < PIPE_DEPTH; i++) begin
            pipe_r[i] <= pipe_r[i-1];
         end
      end
   end

   logic [FIFO_W-1:0] fifoOut;

   two_entry_buffer #(
      .W(FIFO_W)
   ) u_two_entry_buffer (
      .clk(clk),
      .rst_b(rst_b),
      .clkEn(clkEn),
      .inValid(pipeValid_r[PIPE_DEPTH-1] && advance),
      .inData(pipe_r[PIPE_DEPTH-1]),
      .inReady(fifoInReady),
      .outValid(sampleValid),
      .outData(fifoOut),
      .outReady(sampleReady)
   );

   // Flag and word leave the buffer as one register
   assign overrangeFlag = fifoOut[WORD_W];
   assign sampleWord = fifoOut[WORD_W-1:0];

   // Helper: consecutive enabled cycles, saturating
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         enRun_r <= 4'h0;
      end else begin
         enRun_r <= clkEn ? ((enRun_r == 4'hF) ? enRun_r : enRun_r + 4'h1) : 4'h0;
      end
   end

   property p_mid_code;
      @(posedge clk) disable iff (!rst_b)
      (advance && heldSample_r == 0) |=> (pipe_r[0] == {1'b0, CODE_MID});
   endproperty
   a_mid_code: assert property (p_mid_code)
      else $error("Zero input did not give midpoint code");

   property p_neg_fs;
      @(posedge clk) disable iff (!rst_b)
      (advance && offs == 0) |=> (pipe_r[0] == {1'b0, CODE_MIN});
   endproperty
   a_neg_fs: assert property (p_neg_fs)
      else $error("Negative full scale did not give zero code");

   property p_ovr_high;
      @(posedge clk) disable iff (!rst_b)
      (advance && above) |=> (pipe_r[0] == {1'b1, CODE_MAX});
   endproperty
   a_ovr_high: assert property (p_ovr_high)
      else $error("Input above range not flagged");

   property p_ovr_low;
      @(posedge clk) disable iff (!rst_b)
      (advance && !below && !above) |=> !pipe_r[0][WORD_W];
   endproperty
   a_ovr_low: assert property (p_ovr_low)
      else $error("In-range input flagged");

   property p_flag_aligned;
      @(posedge clk) disable iff (!rst_b)
      (sampleValid && overrangeFlag) |-> (sampleWord == CODE_MAX || sampleWord == CODE_MIN);
   endproperty
   a_flag_aligned: assert property (p_flag_aligned)
      else $error("Flag separated from its sample word");

   property p_int_range;
      @(posedge clk) disable iff (!rst_b)
      (clkEn && rangeSelectPinDriven && rangeSelectPin && referenceSourceSelectDriven
      && !referenceSourceSelect) [*3] |-> (activeSpan == SPAN_LARGE_MV);
   endproperty
   a_int_range: assert property (p_int_range)
      else $error("Internal span does not follow range pin");

   property p_open_pins;
      @(posedge clk) disable iff (!rst_b)
      (clkEn && !referenceSourceSelectDriven) [*3]
      |-> (refExternal && activeSpan == extSpan);
   endproperty
   a_open_pins: assert property (p_open_pins)
      else $error("Open reference pin did not select external mode");

   property p_open_range;
      @(posedge clk) disable iff (!rst_b)
      (clkEn && !rangeSelectPinDriven && referenceSourceSelectDriven && !referenceSourceSelect)
      [*3] |-> (activeSpan == SPAN_SMALL_MV);
   endproperty
   a_open_range: assert property (p_open_range)
      else $error("Open range pin did not give small span");

   property p_ext_ignores_range;
      @(posedge clk) disable iff (!rst_b)
      (refExternal && $stable(refExternal) && $changed(rangeLarge) && $stable(extSpan))
      |-> $stable(activeSpan);
   endproperty
   a_ext_ignores_range: assert property (p_ext_ignores_range)
      else $error("Range pin changed span in external mode");

   property p_ref_latency;
      @(posedge clk) disable iff (!rst_b)
      (enRun_r >= 4'd9) |-> (extSpan == $past(extSpanRaw, REF_DLY_STAGES));
   endproperty
   a_ref_latency: assert property (p_ref_latency)
      else $error("External reference latency wrong");

   c_overrange: cover property (@(posedge clk) disable iff (!rst_b)
      sampleValid && sampleReady && overrangeFlag);
   c_stall: cover property (@(posedge clk) disable iff (!rst_b)
      sampleValid && !sampleReady ##1 !fifoInReady);
   c_external: cover property (@(posedge clk) disable iff (!rst_b)
      refExternal && sampleValid && sampleReady);
   c_large: cover property (@(posedge clk) disable iff (!rst_b)
      !refExternal && rangeLarge && sampleValid);
endmodule // adc_sample_output

//--- design/two_entry_buffer.sv
// Two-entry buffer with valid and ready on both sides, registered outputs
`timescale 1ns/10ps
module two_entry_buffer #(
   parameter int W = 13
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clkEn,
   // Fill side
   input wire logic inValid,
   input wire logic [W-1:0] inData,
   output logic inReady,
   // Drain side
   output logic outValid,
   output logic [W-1:0] outData,
   input wire logic outReady
);
   logic [1:0] count_r;
   logic [1:0] count_nxt;
   logic [W-1:0] tail_r;
   wire logic push = inValid && inReady;
   wire logic pop = outValid && outReady;

   always_comb begin
      count_nxt = count_r;
      if (push && !pop) begin
         count_nxt = count_r + 2'd1;
      end else if (pop && !push) begin
         count_nxt = count_r - 2'd1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         count_r <= 2'd0;
         outValid <= 1'b0;
         inReady <= 1'b0;
         outData <= '0;
         tail_r <= '0;
      end else if (clkEn) begin
         count_r <= count_nxt;
         outValid <= (count_nxt != 2'd0);
         inReady <= (count_nxt != 2'd2);
         if (pop) begin
            outData <= (count_r == 2'd2) ? tail_r : inData;
         end else if (push && count_r == 2'd0) begin
            outData <= inData;
         end
         if (push && (count_r == 2'd2 || (count_r == 2'd1 && !pop))) begin
            tail_r <= inData;
         end
      end
   end

   // A stalled word must hold still until the receiver takes it
   property p_hold_on_stall;
      @(posedge clk) disable iff (!rst_b)
      (outValid && !outReady) |=> (outValid && $stable(outData));
   endproperty
   a_hold_on_stall: assert property (p_hold_on_stall)
      else $error("Buffer output changed while stalled");

   property p_full_refuses;
      @(posedge clk) disable iff (!rst_b)
      (count_r == 2'd2) |-> !inReady;
   endproperty
   a_full_refuses: assert property (p_full_refuses)
      else $error("Buffer accepts while full");
endmodule // two_entry_buffer

//--- verification/capture_model.sv
// Capture logic model: takes sample words and over-range flags from the converter
`timescale 1ns/10ps
module capture_model
   import adc_out_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clkEn,
   // Stream from converter
   input wire logic [WORD_W-1:0] sampleWord,
   input wire logic overrangeFlag,
   input wire logic sampleValid,
   output logic sampleReady,
   // Control and results
   input wire logic slowMode,
   output logic [WORD_W-1:0] lastWord,
   output logic [WORD_W-1:0] lastTwos,
   output logic lastFlag,
   output logic [15:0] capCnt
);
   logic [1:0] paceCnt;
   // Slow mode takes one word in four so the buffer fills and stalls
   always @(negedge clk) begin
      paceCnt <= paceCnt + 2'h1;
      sampleReady <= !slowMode || (paceCnt == 2'h0);
   end
   initial paceCnt = 2'h0;
   initial sampleReady = 1'b0;
   // Word and flag latched on the same edge, one latency for both
   always @(posedge clk) begin
      if (!rst_b) begin
         capCnt <= 16'h0000;
         lastWord <= 12'h000;
         lastTwos <= 12'h000;
         lastFlag <= 1'b0;
      end else if (clkEn && sampleValid && sampleReady) begin
         lastWord <= sampleWord;
         lastFlag <= overrangeFlag;
         lastTwos <= {~sampleWord[WORD_W-1], sampleWord[WORD_W-2:0]};
         capCnt <= capCnt + 16'h0001;
      end
   end
endmodule // capture_model

//--- verification/tb_adc_sample_output.sv
// Self-checking testbench for the converter sample output block
`timescale 1ns/10ps
module tb_adc_sample_output;
   import adc_out_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, clkEn = 1'b1, slowMode = 1'b0;
   logic signed [MV_W-1:0] diffInMv = 16'sh0000;
   logic [MV_W-1:0] refTopMv = 16'h0DAC, refBotMv = 16'h03E8;
   logic rangeSelectPin = 1'b0, rangeSelectPinDriven = 1'b1;
   logic referenceSourceSelect = 1'b0, referenceSourceSelectDriven = 1'b1;
   logic [WORD_W-1:0] sampleWord, lastWord, lastTwos;
   logic overrangeFlag, sampleValid, sampleReady, lastFlag;
   logic [15:0] capCnt;
   int error_cnt = 0, compares = 0;
   // Symmetric clock, equal high and low times
   always #10 clk = ~clk;
   adc_sample_output u_adc_sample_output (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
      .diffInMv(diffInMv), .refTopMv(refTopMv), .refBotMv(refBotMv),
      .rangeSelectPin(rangeSelectPin), .rangeSelectPinDriven(rangeSelectPinDriven),
      .referenceSourceSelect(referenceSourceSelect),
      .referenceSourceSelectDriven(referenceSourceSelectDriven), .sampleWord(sampleWord),
      .overrangeFlag(overrangeFlag), .sampleValid(sampleValid), .sampleReady(sampleReady));
   capture_model u_capture_model (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
      .sampleWord(sampleWord), .overrangeFlag(overrangeFlag), .sampleValid(sampleValid),
      .sampleReady(sampleReady), .slowMode(slowMode), .lastWord(lastWord),
      .lastTwos(lastTwos), .lastFlag(lastFlag), .capCnt(capCnt));
   task automatic cmpWord(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmpBit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic waitCyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Holds one input long enough to flush pipeline and buffer, then judges the capture
   task automatic conv(input int mv, input int span);
      logic [WORD_W-1:0] expW;
      logic expF;
      diffInMv = 16'(mv);
      waitCyc(20);
      expF = (mv >= span / 2) || (mv < -(span / 2));
      expW = (mv >= span / 2) ? CODE_MAX : (mv < -(span / 2)) ? CODE_MIN :
         WORD_W'(((mv + span / 2) * 4096) / span);
      cmpWord(lastWord, expW);
      cmpBit(lastFlag, expF);
      cmpWord(lastTwos, expW ^ CODE_MID);
   endtask
   task automatic t_coding;
      int pts[8] = '{0, -1000, 999, 500, -500, 1000, -1001, 1};
      foreach (pts[i]) conv(pts[i], 2000);
      $display("test coding done");
   endtask
   task automatic t_range;
      rangeSelectPin = 1'b1;
      waitCyc(30);
      conv(1200, 3000);
      conv(1500, 3000);
      rangeSelectPinDriven = 1'b0;
      waitCyc(30);
      conv(1200, 2000);
      $display("test range done");
   endtask
   task automatic t_extref;
      referenceSourceSelect = 1'b1;
      waitCyc(30);
      conv(1200, 2500);
      rangeSelectPinDriven = 1'b1;
      rangeSelectPin = 1'b1;
      waitCyc(30);
      conv(1200, 2500);
      referenceSourceSelect = 1'b0;
      referenceSourceSelectDriven = 1'b0;
      waitCyc(30);
      conv(1249, 2500);
      refTopMv = 16'h0BB8;
      waitCyc(30);
      conv(1249, 2000);
      $display("test external reference done");
   endtask
   // Word and flag must turn over on the very same beat
   task automatic t_pairing;
      int n;
      conv(0, 2000);
      diffInMv = 16'sh03E8;
      n = 0;
      while (sampleWord !== CODE_MAX && n < 40) begin
         cmpBit(overrangeFlag, 1'b0);
         @(negedge clk);
         n++;
      end
      cmpBit(overrangeFlag, 1'b1);
      cmpBit(n < 40, 1'b1);
      // Two capture flops, the pipeline stages, then the buffer head register
      cmpBit(n == PIPE_DEPTH + SYNC_STAGES + 1, 1'b1);
      $display("test pairing done");
   endtask
   // Rising ramp under a slow receiver: no word repeated out of order
   task automatic t_stall;
      logic [WORD_W-1:0] prev;
      logic [15:0] cnt0;
      conv(-800, 2000);
      prev = lastWord;
      cnt0 = capCnt;
      slowMode = 1'b1;
      for (int i = 0; i < 60; i++) begin
         diffInMv = 16'(-800 + 4 * i);
         @(negedge clk);
         cmpBit(lastWord >= prev, 1'b1);
         prev = lastWord;
      end
      cmpBit(capCnt - cnt0 > 16'h000A, 1'b1);
      slowMode = 1'b0;
      conv(-564, 2000);
      $display("test stall done");
   endtask
   // Mid-run reset: outputs cleared, no word offered until the pipeline refills
   task automatic t_reset;
      rst_b = 1'b0;
      waitCyc(2);
      cmpBit(sampleValid, 1'b0);
      cmpWord(sampleWord, CODE_MIN);
      cmpBit(overrangeFlag, 1'b0);
      rst_b = 1'b1;
      waitCyc(2);
      cmpBit(sampleValid, 1'b0);
      waitCyc(20);
      cmpBit(sampleValid, 1'b1);
      $display("test reset done");
   endtask
   // Enable low freezes the output and the receiver sees no new word
   task automatic t_freeze;
      logic [WORD_W-1:0] w0;
      logic [15:0] c0;
      conv(200, 2000);
      clkEn = 1'b0;
      w0 = sampleWord;
      c0 = capCnt;
      diffInMv = 16'sh0190;
      waitCyc(12);
      cmpWord(sampleWord, w0);
      cmpBit(sampleValid, 1'b1);
      cmpBit(capCnt == c0, 1'b1);
      clkEn = 1'b1;
      conv(400, 2000);
      $display("test freeze done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      waitCyc(12);
      rst_b = 1'b1;
      waitCyc(4);
      t_coding();
      t_range();
      t_extref();
      t_pairing();
      t_stall();
      t_reset();
      t_freeze();
      summarize();
   end
   initial begin
      #100000;
      error_cnt++;
      summarize();
   end
endmodule // tb_adc_sample_output
